// [src/isa_state_pkg.sv]
// Shared constants and types for the instruction-set state selector
// Functional notes
// RULE_01 - In the narrow state the decoder uses the fixed word set when both selection bits are 0 and the mixed-length set when the thumb bit is 1.
// RULE_02 - A state with the bytecode bit at 1 is never entered, with either value of the thumb bit.
// RULE_03 - The fixed set fetches word-aligned 32-bit instructions and the mixed set halfword-aligned 16/32-bit ones.
// RULE_04 - Switching between the two narrow sets leaves mode and register contents unchanged.
// RULE_05 - Branch-exchange-to-bytecode is executed exactly as plain branch-exchange.
// RULE_06 - Instruction bytes are always taken little-endian whatever the data byte order.
// RULE_07 - Memory is byte addressed upward from zero and data may be stored big- or little-endian.
// RULE_08 - The execution state may change only together with a change of privilege level.
// RULE_09 - The wide state offers 31 general registers of 64 bits plus 64-bit counter, stack pointer and link registers.
// RULE_10 - The wide state maps 64-bit virtual addresses to a 40-bit physical space.
// RULE_11 - The narrow state offers 13 general registers of 32 bits plus 32-bit counter, stack pointer and link register.
// RULE_12 - The narrow state uses 32-bit virtual addresses mapped to physical addresses of up to 40 bits.
// RULE_13 - All four privilege levels exist and each may run in either execution state.
// RULE_14 - The narrow state keeps its selection bits in one current program status register.
// RULE_15 - Reset enters the highest privilege level in the execution state given by a configuration input.
// RULE_16 - The bytecode bit is held at zero so an attempt to set it leaves the selection unchanged.
package isa_state_pkg;
	localparam int WIDE_GPR_COUNT   = 31;
	localparam int WIDE_REG_WIDTH   = 64;
	localparam int NARROW_GPR_COUNT = 13;
	localparam int NARROW_REG_WIDTH = 32;
	localparam int PHYS_ADDR_WIDTH  = 40;
	localparam int WIDE_VA_WIDTH    = 64;
	localparam int NARROW_VA_WIDTH  = 32;
	localparam int PSR_THUMB_BIT    = 5;
	localparam int PSR_BYTECODE_BIT = 24;
	localparam logic [1:0]  TOP_PRIV_LEVEL  = 2'h3;
	localparam logic [31:0] PSR_RESET_VALUE = 32'h0000_01d3;
	localparam logic [2:0]  FIX_ALIGN_MASK  = 3'h3;
	localparam logic [2:0]  MIX_ALIGN_MASK  = 3'h1;
	localparam logic [2:0]  WIDE_ALIGN_MASK = 3'h3;

	typedef enum logic [2:0] {
		ISA_FIXED = 3'b001,
		ISA_MIXED = 3'b010,
		ISA_WIDE  = 3'b100
	} isa_sel_t;

	typedef struct packed {
		logic        valid;
		logic        to_wide;
		logic [1:0]  level;
	} state_change_t;

	typedef struct packed {
		logic        valid;
		logic        is_bytecode_bx;
		logic [31:0] target;
	} branch_req_t;
endpackage : isa_state_pkg

// [src/isa_state_select.sv]
// Instruction-set and execution-state tracking for the core front end
`timescale 1ns/10ps
`default_nettype none
module isa_state_select (
	// Clock and reset
	input  wire logic                          i_core_clk,
	input  wire logic                          i_reset_n,
	// Configuration
	input  wire logic                          i_cfg_reset_wide,
	input  wire logic                          i_data_big_endian,
	// Execution-state change with privilege level
	input  wire isa_state_pkg::state_change_t  i_state_change,
	// Status register write in the narrow state
	input  wire logic                          i_psr_wr,
	input  wire logic [31:0]                   i_psr_wdata,
	// Branch-and-exchange requests
	input  wire isa_state_pkg::branch_req_t    i_branch,
	// Fetch path
	input  wire logic [63:0]                   i_fetch_addr,
	input  wire logic [31:0]                   i_fetch_bytes,
	// Data path byte order
	input  wire logic [63:0]                   i_store_word,
	// State outputs
	output logic                               o_wide_state,
	output logic [1:0]                         o_priv_level,
	output isa_state_pkg::isa_sel_t            o_isa_sel,
	output logic [31:0]                        o_current_program_status_reg,
	output logic [6:0]                         o_reg_width,
	output logic [5:0]                         o_gpr_count,
	output logic [6:0]                         o_va_width,
	output logic [5:0]                         o_pa_width,
	// Fetch and data results
	output logic                               o_fetch_misaligned,
	output logic [31:0]                        o_instr_word,
	output logic [63:0]                        o_mem_word,
	output logic                               o_state_change_reject,
	output logic [31:0]                        o_branch_pc
);
	import isa_state_pkg::*;

	logic        wide_ff;
	logic [1:0]  level_ff;
	logic [31:0] psr_ff;
	logic        first_ff;
	logic        cfg_meta_ff;
	logic        cfg_sync_ff;
	logic        reject_ff;
	logic [31:0] instr_ff;
	logic [63:0] mem_ff;
	logic        misalign_ff;
	logic [31:0] branch_pc_ff;
	logic [31:0] nxt_psr;
	logic        level_moves;
	isa_sel_t    isa_now;

	function automatic isa_sel_t decode_isa(input logic wide, input logic [31:0] psr);
		if (wide)
			return ISA_WIDE;
		else if (psr[PSR_THUMB_BIT])                   // [RULE_01]
			return ISA_MIXED;
		else
			return ISA_FIXED;
	endfunction : decode_isa

	assign isa_now = decode_isa(wide_ff, psr_ff);

	// Strap keeps sampling through reset so its level is ready at release
	always_ff @(posedge i_core_clk) begin
		cfg_meta_ff <= i_cfg_reset_wide;
		cfg_sync_ff <= cfg_meta_ff;                         // [RULE_15]
	end

	assign level_moves = i_state_change.valid && (i_state_change.level != level_ff);

	// Execution state and privilege level
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			first_ff  <= 1'b1;
			wide_ff   <= 1'b0;
			level_ff  <= TOP_PRIV_LEVEL;                     // [RULE_15]
			reject_ff <= 1'b0;
		end else begin
			first_ff  <= 1'b0;
			reject_ff <= 1'b0;
			if (first_ff) begin
				wide_ff <= cfg_sync_ff;                       // [RULE_15]
			end else if (i_state_change.valid) begin
				level_ff <= i_state_change.level;             // [RULE_13]
				if (level_moves)
					wide_ff <= i_state_change.to_wide;           // [RULE_08]
				else if (i_state_change.to_wide != wide_ff)
					reject_ff <= 1'b1;                            // [RULE_08]
			end
		end
	end

	// Status register write keeps the bytecode bit clear
	always_comb begin
		nxt_psr = psr_ff;
		if (i_psr_wr && !wide_ff) begin
			if (i_psr_wdata[PSR_BYTECODE_BIT])
				nxt_psr = psr_ff;                             // [RULE_16]
			else
				nxt_psr = i_psr_wdata;                        // [RULE_14]
		end
		if (i_branch.valid && !wide_ff)
			nxt_psr[PSR_THUMB_BIT] = i_branch.target[0];      // [RULE_05]
		nxt_psr[PSR_BYTECODE_BIT] = 1'b0;                   // [RULE_02]
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			psr_ff <= PSR_RESET_VALUE;
		else
			psr_ff <= nxt_psr;                                // [RULE_04]
	end

	// Branch target alignment; bytecode form behaves as plain form
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			branch_pc_ff <= 32'h0;
		else if (i_branch.valid)
			branch_pc_ff <= {i_branch.target[31:1], 1'b0};    // [RULE_05]
	end

	// Fetch: little-endian instruction bytes and alignment check
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			instr_ff    <= 32'h0;
			misalign_ff <= 1'b0;
		end else begin
			instr_ff <= i_fetch_bytes;                        // [RULE_06]
			case (isa_now)
				ISA_FIXED: misalign_ff <= |(i_fetch_addr[2:0] & FIX_ALIGN_MASK);  // [RULE_03]
				ISA_MIXED: misalign_ff <= |(i_fetch_addr[2:0] & MIX_ALIGN_MASK);  // [RULE_03]
				ISA_WIDE:  misalign_ff <= |(i_fetch_addr[2:0] & WIDE_ALIGN_MASK);
				default:   misalign_ff <= 1'b0;
			endcase
		end
	end

	// Data byte order: byte 0 is lowest address
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			mem_ff <= 64'h0;
		else if (i_data_big_endian)
			mem_ff <= {<<8{i_store_word}};                    // [RULE_07]
		else
			mem_ff <= i_store_word;                           // [RULE_07]
	end

	// Architectural widths of the current state
	always_comb begin
		if (wide_ff) begin
			o_reg_width = 7'(WIDE_REG_WIDTH);                  // [RULE_09]
			o_gpr_count = 6'(WIDE_GPR_COUNT);                  // [RULE_09]
			o_va_width  = 7'(WIDE_VA_WIDTH);                   // [RULE_10]
		end else begin
			o_reg_width = 7'(NARROW_REG_WIDTH);                // [RULE_11]
			o_gpr_count = 6'(NARROW_GPR_COUNT);                // [RULE_11]
			o_va_width  = 7'(NARROW_VA_WIDTH);                 // [RULE_12]
		end
		o_pa_width = 6'(PHYS_ADDR_WIDTH);                    // [RULE_10] [RULE_12]
	end

	assign o_wide_state                 = wide_ff;
	assign o_priv_level                 = level_ff;
	assign o_isa_sel                    = isa_now;
	assign o_current_program_status_reg = psr_ff;
	assign o_fetch_misaligned           = misalign_ff;
	assign o_instr_word                 = instr_ff;
	assign o_mem_word                   = mem_ff;
	assign o_state_change_reject        = reject_ff;
	assign o_branch_pc                  = branch_pc_ff;

	// Checks
	sequence same_level_req;
		i_state_change.valid && (i_state_change.level == level_ff) && !first_ff;
	endsequence

	sequence state_move_req;
		level_moves && !first_ff;
	endsequence

	sequence psr_plain_write;
		i_psr_wr && !wide_ff && !i_psr_wdata[PSR_BYTECODE_BIT] && !i_branch.valid;
	endsequence

	// Status register
	chk_no_bytecode_state: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_02]
		!psr_ff[PSR_BYTECODE_BIT])
		else $error("bytecode bit set");

	chk_bytecode_write_ignored: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_16]
		(i_psr_wr && i_psr_wdata[PSR_BYTECODE_BIT] && !i_branch.valid && !first_ff) |=> $stable(psr_ff))
		else $error("bytecode write changed status");

	chk_psr_write_lands: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_14]
		psr_plain_write |=> psr_ff == $past(i_psr_wdata))
		else $error("status write lost");

	chk_wide_psr_frozen: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_14]
		(wide_ff && !first_ff) |=> $stable(psr_ff))
		else $error("status changed in wide state");

	chk_reset_psr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_14]
		first_ff |-> psr_ff == PSR_RESET_VALUE)
		else $error("status reset value wrong");

	chk_narrow_bits_kept: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_04]
		(i_branch.valid && !i_psr_wr) |=> $stable(psr_ff[31:6]) && $stable(psr_ff[4:0]))
		else $error("set switch disturbed mode bits");

	// State and level
	chk_state_needs_level: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_08]
		(!first_ff && !$past(first_ff) && $changed(wide_ff)) |-> $changed(level_ff))
		else $error("state changed without level change");

	chk_same_level_reject: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_08]
		same_level_req and (i_state_change.to_wide != wide_ff) |=> reject_ff && $stable(wide_ff))
		else $error("same-level state change not refused");

	chk_no_reject_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_08]
		(!i_state_change.valid || first_ff) |=> !reject_ff)
		else $error("reject without request");

	chk_level_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_08]
		(!first_ff && !i_state_change.valid) |=> $stable(level_ff) && $stable(wide_ff))
		else $error("state moved without request");

	chk_level_follows: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_13]
		(i_state_change.valid && !first_ff) |=> level_ff == $past(i_state_change.level))
		else $error("level not taken");

	chk_state_move: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_13]
		state_move_req |=> wide_ff == $past(i_state_change.to_wide))
		else $error("state not taken with level");

	chk_reset_top_level: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_15]
		first_ff |-> level_ff == TOP_PRIV_LEVEL ##1 wide_ff == $past(cfg_sync_ff))
		else $error("reset state wrong");

	chk_first_once: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_15]
		first_ff |=> !first_ff)
		else $error("reset load repeated");

	// Instruction set selection and branches
	chk_isa_decode: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_01]
		!wide_ff |-> (o_isa_sel == (psr_ff[PSR_THUMB_BIT] ? ISA_MIXED : ISA_FIXED)))
		else $error("narrow set decode wrong");

	chk_wide_sel: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_09]
		wide_ff |-> o_isa_sel == ISA_WIDE)
		else $error("wide set not selected");

	chk_bx_equiv: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_05]
		(i_branch.valid && !wide_ff && !i_psr_wr) |=> psr_ff[PSR_THUMB_BIT] == $past(i_branch.target[0]))
		else $error("branch exchange state wrong");

	chk_bytecode_bx_plain: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_05]
		(i_branch.valid && i_branch.is_bytecode_bx && !wide_ff && !i_psr_wr)
		|=> psr_ff[PSR_THUMB_BIT] == $past(i_branch.target[0]) && !psr_ff[PSR_BYTECODE_BIT])
		else $error("bytecode branch not plain");

	chk_branch_pc: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_05]
		i_branch.valid |=> branch_pc_ff == {$past(i_branch.target[31:1]), 1'b0})
		else $error("branch target wrong");

	// Fetch and data
	chk_fixed_align: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_03]
		(isa_now == ISA_FIXED && i_fetch_addr[1:0] != 2'h0) |=> misalign_ff)
		else $error("fixed set misalignment missed");

	chk_fixed_aligned_ok: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_03]
		(isa_now == ISA_FIXED && i_fetch_addr[1:0] == 2'h0) |=> !misalign_ff)
		else $error("word fetch flagged");

	chk_mixed_align: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_03]
		(isa_now == ISA_MIXED && i_fetch_addr[1:0] == 2'h2) |=> !misalign_ff)
		else $error("halfword fetch flagged");

	chk_mixed_odd: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_03]
		(isa_now == ISA_MIXED && i_fetch_addr[0]) |=> misalign_ff)
		else $error("odd fetch not flagged");

	chk_instr_little: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_06]
		i_data_big_endian |=> instr_ff == $past(i_fetch_bytes))
		else $error("instruction bytes swapped");

	chk_instr_always: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_06]
		!i_data_big_endian |=> instr_ff == $past(i_fetch_bytes))
		else $error("instruction bytes altered");

	chk_big_endian_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_07]
		i_data_big_endian |=> mem_ff[7:0] == $past(i_store_word[63:56]))
		else $error("big-endian byte order wrong");

	chk_little_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_07]
		!i_data_big_endian |=> mem_ff == $past(i_store_word))
		else $error("little-endian data altered");

	// Architectural widths
	chk_widths: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_09] [RULE_11]
		wide_ff ? (o_gpr_count == 6'h1f && o_reg_width == 7'h40) : (o_gpr_count == 6'h0d && o_reg_width == 7'h20))
		else $error("register widths wrong");

	chk_va_width: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_10] [RULE_12]
		o_va_width == (wide_ff ? 7'h40 : 7'h20))
		else $error("virtual address width wrong");

	chk_pa_width: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)  // [RULE_10] [RULE_12]
		o_pa_width == 6'h28)
		else $error("physical address width wrong");
endmodule : isa_state_select
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking testbench for the instruction-set state selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD %0t mismatch %h vs %h", $time, (got), (exp)); end end
module tb_top;
	import isa_state_pkg::*;
	logic                i_core_clk = 1'b0, i_reset_n = 1'b0, i_cfg_reset_wide = 1'b0;
	logic                i_data_big_endian = 1'b1, i_psr_wr = 1'b0;
	logic [31:0]         i_psr_wdata = 32'h0, i_fetch_bytes = 32'h0;
	logic [63:0]         i_fetch_addr = 64'h0, i_store_word = 64'h0;
	state_change_t       i_state_change = '0;
	branch_req_t         i_branch = '0;
	logic                o_wide_state, o_fetch_misaligned, o_state_change_reject;
	logic [1:0]          o_priv_level;
	isa_sel_t            o_isa_sel;
	logic [31:0]         o_psr, o_instr_word, o_branch_pc;
	logic [6:0]          o_reg_width, o_va_width;
	logic [5:0]          o_gpr_count, o_pa_width;
	logic [63:0]         o_mem_word;
	int                  num_errors = 0, compares = 0;
	always #50 i_core_clk = ~i_core_clk;
	isa_state_select dut_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_cfg_reset_wide(i_cfg_reset_wide), .i_data_big_endian(i_data_big_endian),
		.i_state_change(i_state_change), .i_psr_wr(i_psr_wr), .i_psr_wdata(i_psr_wdata),
		.i_branch(i_branch), .i_fetch_addr(i_fetch_addr), .i_fetch_bytes(i_fetch_bytes),
		.i_store_word(i_store_word), .o_wide_state(o_wide_state), .o_priv_level(o_priv_level),
		.o_isa_sel(o_isa_sel), .o_current_program_status_reg(o_psr),
		.o_reg_width(o_reg_width), .o_gpr_count(o_gpr_count), .o_va_width(o_va_width),
		.o_pa_width(o_pa_width), .o_fetch_misaligned(o_fetch_misaligned),
		.o_instr_word(o_instr_word), .o_mem_word(o_mem_word),
		.o_state_change_reject(o_state_change_reject), .o_branch_pc(o_branch_pc));
	task automatic cyc(input int n = 1);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : cyc
	task automatic t_reset;
		`CHK({o_priv_level, o_wide_state, o_psr}, {TOP_PRIV_LEVEL, 1'b0, PSR_RESET_VALUE})
		`CHK(o_isa_sel, ISA_FIXED)
		`CHK({o_reg_width, o_gpr_count, o_va_width, o_pa_width}, {7'h20, 6'hd, 7'h20, 6'h28})
	endtask : t_reset
	task automatic psr_write(input logic [31:0] d);
		i_psr_wr = 1'b1;
		i_psr_wdata = d;
		cyc();
		i_psr_wr = 1'b0;
		cyc();
	endtask : psr_write
	task automatic t_fetch(input logic mixed);
		for (int a = 0; a < 4; a++) begin
			i_fetch_addr = {62'h1000, a[1:0]};
			i_fetch_bytes = 32'h1122_3344 + a;
			cyc();
			`CHK(o_fetch_misaligned, mixed ? a[0] : (a[1:0] != 2'h0))
			`CHK(o_instr_word, 32'h1122_3344 + a)
		end
	endtask : t_fetch
	task automatic t_psr;
		psr_write(PSR_RESET_VALUE | 32'h20);
		`CHK(o_isa_sel, ISA_MIXED)
		`CHK(o_psr, PSR_RESET_VALUE | 32'h20)
		t_fetch(1'b1);
		psr_write(PSR_RESET_VALUE | 32'h0100_0000);
		`CHK({o_psr[24], o_psr[5]}, 2'b01)
		`CHK(o_isa_sel, ISA_MIXED)
		psr_write(PSR_RESET_VALUE);
		`CHK({o_isa_sel, o_priv_level, o_psr}, {ISA_FIXED, 2'h3, PSR_RESET_VALUE})
		t_fetch(1'b0);
	endtask : t_psr
	task automatic t_branch;
		i_branch = '{valid: 1'b1, is_bytecode_bx: 1'b1, target: 32'h0000_1235};
		cyc();
		i_branch = '{valid: 1'b1, is_bytecode_bx: 1'b0, target: 32'h0000_4000};
		`CHK({o_branch_pc, o_isa_sel}, {32'h0000_1234, ISA_MIXED})
		cyc();
		i_branch = '0;
		`CHK({o_branch_pc, o_isa_sel}, {32'h0000_4000, ISA_FIXED})
	endtask : t_branch
	task automatic t_store;
		i_store_word = 64'h0011_2233_4455_6677;
		cyc();
		`CHK(o_mem_word, 64'h7766_5544_3322_1100)
		i_data_big_endian = 1'b0;
		cyc();
		`CHK(o_mem_word, 64'h0011_2233_4455_6677)
	endtask : t_store
	task automatic req(input logic w, input logic [1:0] lv);
		i_state_change = '{valid: 1'b1, to_wide: w, level: lv};
		cyc();
		i_state_change = '0;
	endtask : req
	task automatic t_state;
		req(1'b1, 2'h3);
		`CHK({o_state_change_reject, o_wide_state, o_priv_level}, 4'b1011)
		cyc();
		`CHK(o_state_change_reject, 1'b0)
		req(1'b0, 2'h1);
		`CHK({o_wide_state, o_priv_level}, 3'b001)
		cyc();
		req(1'b1, 2'h2);
		`CHK({o_wide_state, o_priv_level, o_isa_sel}, {3'b110, ISA_WIDE})
		`CHK({o_reg_width, o_gpr_count, o_va_width, o_pa_width}, {7'h40, 6'h1f, 7'h40, 6'h28})
		psr_write(PSR_RESET_VALUE | 32'h20);
		`CHK(o_isa_sel, ISA_WIDE)
	endtask : t_state
	task automatic t_strap;
		i_cfg_reset_wide = 1'b1;
		cyc(3);
		i_reset_n = 1'b0;
		cyc(2);
		i_reset_n = 1'b1;
		cyc(3);
		`CHK({o_wide_state, o_priv_level, o_isa_sel}, {3'b111, ISA_WIDE})
	endtask : t_strap
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		cyc(2);
		i_reset_n = 1'b1;
		cyc(2);
		t_reset();
		t_psr();
		t_branch();
		t_store();
		t_state();
		t_strap();
		conclude();
	end
	initial begin
		cyc(5000);
		num_errors++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
